// *** cdcfg_regs.v ***
// divider configuration register bank, registers 03h to 07h, with the
// serial write port and the general output pin multiplexer
// assumes clk is the input clock; serial clock, load strobe and pins are asynchronous
//
// Functional notes
// - swing code 0..3 selects 600 to 900 mV single-ended, 100 mV steps.
// - startup delay trim adds 1000 ps plus code times 80 ps.
// - broadcast bit lets frames with chip address all ones be accepted.
// - external startup enable lets the startup pin release the divider.
// - external cycle-drop enable makes the pin request a synchronous cycle drop.
// - bias select bit chooses DC bias for AC-coupled non-ECL inputs.
// - fine delay enable routes through delay line, else low-noise bypass.
// - regulator bypass bit set bypasses the on-chip regulator.
// - output select code picks constant, request or state for general output.
// - force-general-output stops automatic switch to serial read data.
// - force-serial-out keeps serial data only and wins over force-general.
// - high-impedance bit floats the general output pin unconditionally.
// - software startup bit 0 holds divider reset, 1 releases; resets to 1.
// - each rising software cycle-drop bit drops one full input cycle.
// - launch phase 0 falling edge early, 1 rising edge late.
// - fine delay is 300 ps plus setpoint times 20 ps, max 1500 ps.
// - frame is 9 data, 4 address, 3 chip bits, MSB first, load on strobe.
`timescale 1ns/1ps
`default_nettype none
`include "cdcfg_consts.vh"
module cdcfg_regs #(
	parameter CHIP_ADDR = 3'h0
) (
	input wire clk,
	input wire resetn,
	input wire serial_clk,
	input wire serial_data_in,
	input wire load_strobe,
	input wire serial_data_out,
	input wire external_startup_pin,
	input wire waiting_for_clock,
	output reg [1:0] swing_code,
	output reg [2:0] startup_trim_code,
	output reg [9:0] swing_mv,
	output reg [10:0] startup_trim_ps,
	output reg input_bias_dc,
	output reg fine_delay_enable,
	output reg regulator_bypass,
	output reg [5:0] delay_setpoint,
	output reg [10:0] fine_delay_ps,
	output reg divider_run,
	output reg startup_request,
	output reg startup_delayed,
	output reg cycle_drop_request,
	output reg cycle_drop_pulse,
	output reg launch_late,
	output wire general_output_pin_o,
	output wire general_output_pin_oe
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	wire sclk_s;
	wire sdi_s;
	wire le_s;
	wire pin_s;
	cdcfg_sync3 #(.RST_VAL(1'b0)) u_sclk (.clk(clk), .resetn(resetn),
		.din(serial_clk), .dout(sclk_s));
	cdcfg_sync3 #(.RST_VAL(1'b0)) u_sdi (.clk(clk), .resetn(resetn),
		.din(serial_data_in), .dout(sdi_s));
	cdcfg_sync3 #(.RST_VAL(1'b0)) u_le (.clk(clk), .resetn(resetn),
		.din(load_strobe), .dout(le_s));
	cdcfg_sync3 #(.RST_VAL(1'b0)) u_pin (.clk(clk), .resetn(resetn),
		.din(external_startup_pin), .dout(pin_s));

	// ----------------------------------------
	// serial shift and frame decode
	// ----------------------------------------
	// sampling serial clock on clk limits the serial rate to well below clk/6
	reg sclk_d_ff;
	reg le_d_ff;
	reg [`CDCFG_FRAME_BITS-1:0] shift_ff;
	wire sclk_rise = sclk_s & ~sclk_d_ff;
	wire le_rise = le_s & ~le_d_ff;
	wire [`CDCFG_DATA_W-1:0] fr_data = shift_ff[15:7];
	wire [`CDCFG_ADDR_W-1:0] fr_addr = shift_ff[6:3];
	wire [`CDCFG_CHIP_W-1:0] fr_chip = shift_ff[2:0];
	reg [8:0] bias_ff;
	reg [8:0] conf_ff;
	reg [8:0] gpo_ff;
	reg [8:0] trig_ff;
	reg [8:0] dly_ff;
	wire chip_hit = (fr_chip == CHIP_ADDR) |
		(conf_ff[`CDCFG_CONF_BCAST] & (fr_chip == `CDCFG_BCAST_CHIP));
	wire commit = le_rise & chip_hit;

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sclk_d_ff <= 1'b0;
			le_d_ff <= 1'b0;
			shift_ff <= 16'h0000;
		end
		else
		begin
			sclk_d_ff <= sclk_s;
			le_d_ff <= le_s;
			if (sclk_rise)
				shift_ff <= {shift_ff[14:0], sdi_s};
		end
	end

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	// reserved bits are kept at reset values; writes to them are dropped
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bias_ff <= `CDCFG_RST_BIAS;
			conf_ff <= `CDCFG_RST_CONF;
			gpo_ff <= `CDCFG_RST_GPO;
			trig_ff <= `CDCFG_RST_TRIG;
			dly_ff <= `CDCFG_RST_DLY;
		end
		else if (commit)
		begin
			case (fr_addr)
				`CDCFG_REG_BIAS: bias_ff <= {fr_data[8:4], 4'hA};
				`CDCFG_REG_CONF: conf_ff <= {3'h0, fr_data[5:0]};
				`CDCFG_REG_GPO: gpo_ff <= {3'h0, fr_data[5:0]};
				`CDCFG_REG_TRIG: trig_ff <= {6'h00, fr_data[2:0]};
				`CDCFG_REG_DLY: dly_ff <= {3'h0, fr_data[5:0]};
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// analog settings decode
	// ----------------------------------------
	reg [5:0] sp_lim;
	always @*
	begin
		sp_lim = dly_ff[5:0];
		if (sp_lim > `CDCFG_FDLY_MAX_CODE)
			sp_lim = `CDCFG_FDLY_MAX_CODE;
	end

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			swing_code <= 2'h2;
			startup_trim_code <= 3'h3;
			swing_mv <= 10'h320;
			startup_trim_ps <= 11'h4D8;
			input_bias_dc <= 1'b0;
			fine_delay_enable <= 1'b0;
			regulator_bypass <= 1'b0;
			delay_setpoint <= 6'h04;
			fine_delay_ps <= 11'h17C;
			launch_late <= 1'b0;
		end
		else
		begin
			swing_code <= bias_ff[5:4];
			swing_mv <= 10'd`CDCFG_SWING_BASE_MV +
				10'd`CDCFG_SWING_STEP_MV * {8'h00, bias_ff[5:4]};
			startup_trim_code <= bias_ff[8:6];
			startup_trim_ps <= 11'd`CDCFG_TRIM_BASE_PS +
				11'd`CDCFG_TRIM_STEP_PS * {8'h00, bias_ff[8:6]};
			input_bias_dc <= conf_ff[`CDCFG_CONF_BIAS];
			fine_delay_enable <= conf_ff[`CDCFG_CONF_FDLY];
			regulator_bypass <= conf_ff[`CDCFG_CONF_REGBYP];
			delay_setpoint <= sp_lim;
			fine_delay_ps <= 11'd`CDCFG_FDLY_BASE_PS +
				11'd`CDCFG_FDLY_STEP_PS * {5'h00, sp_lim};
			launch_late <= trig_ff[`CDCFG_TRIG_PH];
		end
	end

	// ----------------------------------------
	// startup and cycle-drop control
	// ----------------------------------------
	// the host keeps the two pin enables exclusive; cycle drop wins if not
	wire ext_su = conf_ff[`CDCFG_CONF_EXTSU] & ~conf_ff[`CDCFG_CONF_EXTCD];
	wire ext_cd = conf_ff[`CDCFG_CONF_EXTCD];
	reg pin_d_ff;
	reg swcd_d_ff;
	wire sw_cd_rise = trig_ff[`CDCFG_TRIG_CD] & ~swcd_d_ff;
	wire pin_cd_rise = ext_cd & pin_s & ~pin_d_ff;
	wire nxt_run = trig_ff[`CDCFG_TRIG_SU] & (~ext_su | pin_s);

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_d_ff <= 1'b0;
			swcd_d_ff <= 1'b0;
			divider_run <= 1'b0;
			startup_request <= 1'b0;
			startup_delayed <= 1'b0;
			cycle_drop_request <= 1'b0;
			cycle_drop_pulse <= 1'b0;
		end
		else
		begin
			pin_d_ff <= pin_s;
			swcd_d_ff <= trig_ff[`CDCFG_TRIG_CD];
			divider_run <= nxt_run;
			startup_request <= nxt_run;
			startup_delayed <= startup_request;
			cycle_drop_request <= trig_ff[`CDCFG_TRIG_CD] | (ext_cd & pin_s);
			cycle_drop_pulse <= sw_cd_rise | pin_cd_rise;
		end
	end

	// ----------------------------------------
	// general output pin multiplexer
	// ----------------------------------------
	reg sel_ff;
	reg [2:0] gsel;
	reg gval;
	reg out_ff;
	always @*
	begin
		gsel = gpo_ff[2:0];
		case (gsel)
			`CDCFG_SEL_ZERO: gval = 1'b0;
			`CDCFG_SEL_ONE: gval = 1'b1;
			`CDCFG_SEL_CDREQ: gval = cycle_drop_request;
			`CDCFG_SEL_ZERO3: gval = 1'b0;
			`CDCFG_SEL_SUREQ: gval = startup_request;
			`CDCFG_SEL_SUDLY: gval = startup_delayed;
			`CDCFG_SEL_WAIT: gval = waiting_for_clock;
			default: gval = 1'b0;
		endcase
	end

	// automux shows serial read data while the serial clock is high and the load strobe is low
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sel_ff <= 1'b0;
			out_ff <= 1'b0;
		end
		else
		begin
			if (gpo_ff[`CDCFG_GPO_FSDO])
				sel_ff <= 1'b1;
			else if (gpo_ff[`CDCFG_GPO_FGPO])
				sel_ff <= 1'b0;
			else
				sel_ff <= ~le_s & sclk_s;
			out_ff <= sel_ff ? serial_data_out : gval;
		end
	end

	assign general_output_pin_o = out_ff;
	assign general_output_pin_oe = ~gpo_ff[`CDCFG_GPO_HIZ];
endmodule
`default_nettype wire

// *** cdcfg_consts.vh ***
// constants for the divider configuration register bank
// assumes inclusion by bare name from the design files
`ifndef CDCFG_CONSTS_VH
`define CDCFG_CONSTS_VH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define CDCFG_FRAME_BITS 16
`define CDCFG_DATA_W 9
`define CDCFG_ADDR_W 4
`define CDCFG_CHIP_W 3
`define CDCFG_BCAST_CHIP 3'h7

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CDCFG_REG_BIAS 4'h3
`define CDCFG_REG_CONF 4'h4
`define CDCFG_REG_GPO 4'h5
`define CDCFG_REG_TRIG 4'h6
`define CDCFG_REG_DLY 4'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define CDCFG_RST_BIAS 9'h0EA
`define CDCFG_RST_CONF 9'h002
`define CDCFG_RST_GPO 9'h000
`define CDCFG_RST_TRIG 9'h001
`define CDCFG_RST_DLY 9'h004

// ----------------------------------------
// field positions
// ----------------------------------------
`define CDCFG_SWING_LSB 4
`define CDCFG_TRIM_LSB 6
`define CDCFG_CONF_BCAST 0
`define CDCFG_CONF_EXTSU 1
`define CDCFG_CONF_EXTCD 2
`define CDCFG_CONF_BIAS 3
`define CDCFG_CONF_FDLY 4
`define CDCFG_CONF_REGBYP 5
`define CDCFG_GPO_FGPO 3
`define CDCFG_GPO_FSDO 4
`define CDCFG_GPO_HIZ 5
`define CDCFG_TRIG_SU 0
`define CDCFG_TRIG_CD 1
`define CDCFG_TRIG_PH 2

// ----------------------------------------
// analog figures
// ----------------------------------------
`define CDCFG_SWING_BASE_MV 600
`define CDCFG_SWING_STEP_MV 100
`define CDCFG_TRIM_BASE_PS 1000
`define CDCFG_TRIM_STEP_PS 80
`define CDCFG_FDLY_BASE_PS 300
`define CDCFG_FDLY_STEP_PS 20
`define CDCFG_FDLY_MAX_PS 1500
`define CDCFG_FDLY_MAX_CODE 6'h3C

// ----------------------------------------
// general output select codes
// ----------------------------------------
`define CDCFG_SEL_ZERO 3'h0
`define CDCFG_SEL_ONE 3'h1
`define CDCFG_SEL_CDREQ 3'h2
`define CDCFG_SEL_ZERO3 3'h3
`define CDCFG_SEL_SUREQ 3'h4
`define CDCFG_SEL_SUDLY 3'h5
`define CDCFG_SEL_WAIT 3'h6

`endif

// *** cdcfg_sync3.v ***
// three-stage synchroniser with agreement filter
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module cdcfg_sync3 #(
	parameter RST_VAL = 1'b0
) (
	input wire clk,
	input wire resetn,
	input wire din,
	output reg dout
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
			dout <= RST_VAL;
		end
		else
		begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			// change counts only when the last two stages agree
			if (s2_ff == s3_ff)
				dout <= s3_ff;
		end
	end
endmodule
`default_nettype wire

// *** cdcfg_regs_chk_asserts.sv ***
// concurrent checks on the register bank ports
// assumes a bind onto cdcfg_regs from the testbench top
`timescale 1ns/1ps
`default_nettype none
module cdcfg_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic load_strobe,
	input wire logic [1:0] swing_code,
	input wire logic [2:0] startup_trim_code,
	input wire logic [9:0] swing_mv,
	input wire logic [10:0] startup_trim_ps,
	input wire logic [5:0] delay_setpoint,
	input wire logic [10:0] fine_delay_ps,
	input wire logic startup_request,
	input wire logic startup_delayed,
	input wire logic cycle_drop_pulse,
	input wire logic launch_late
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// ----
	// sequences
	// ----
	// eight quiet cycles leave any earlier commit fully settled
	sequence strobe_quiet;
		!load_strobe [*8];
	endsequence
	sequence pulse_gap;
		!cycle_drop_pulse [*4];
	endsequence
	AST_SWING_MV: assert property ($stable(swing_code) |-> swing_mv == 10'h258 + 10'h064 * swing_code)
		else $error("swing level wrong");
	AST_SWING_RANGE: assert property (swing_mv >= 10'h258 && swing_mv <= 10'h384)
		else $error("swing out of range");
	AST_TRIM_PS: assert property ($stable(startup_trim_code) |-> startup_trim_ps == 11'h3E8 + 11'h050 * startup_trim_code)
		else $error("trim delay wrong");
	AST_FDLY_PS: assert property ($stable(delay_setpoint) |-> fine_delay_ps == 11'h12C + 11'h014 * delay_setpoint)
		else $error("fine delay wrong");
	AST_FDLY_MAX: assert property (delay_setpoint <= 6'h3C)
		else $error("setpoint above limit");
	AST_DROP_ONCE: assert property (cycle_drop_pulse |=> pulse_gap)
		else $error("cycle drop pulse repeated");
	AST_SU_DELAYED: assert property (startup_delayed == $past(startup_request))
		else $error("delayed startup not one cycle late");
	AST_NO_COMMIT: assert property (strobe_quiet |-> $stable(swing_code) && $stable(delay_setpoint) && $stable(launch_late))
		else $error("register changed without strobe");
endmodule
`default_nettype wire

// *** cdcfg_host.sv ***
// host serial port model writing configuration frames
// assumes clk is the device input clock; serial clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module cdcfg_host (
	input wire logic clk,
	output logic serial_clk,
	output logic serial_data_in,
	output logic load_strobe
);
	initial
	begin
		serial_clk = 1'b0;
		serial_data_in = 1'b0;
		load_strobe = 1'b0;
	end
	// ----
	// frame: 9 data, 4 address, 3 chip, msb first, levels held at least 5 clk
	// ----
	task automatic send(input logic [15:0] frame);
		for (int i = 15; i >= 0; i--)
		begin
			@(posedge clk);
			serial_data_in <= frame[i];
			repeat (5) @(posedge clk);
			serial_clk <= 1'b1;
			repeat (5) @(posedge clk);
			serial_clk <= 1'b0;
		end
		repeat (5) @(posedge clk);
		load_strobe <= 1'b1;
		// released data line must not keep the last bit
		serial_data_in <= ~frame[0];
		repeat (5) @(posedge clk);
		load_strobe <= 1'b0;
		repeat (10) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the register bank with a host model
// assumes cdcfg_regs, cdcfg_host and cdcfg_chk are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct {string n; int k; logic [10:0] e;} cdcfg_note_t;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic serial_data_out = 1'b0;
	logic external_startup_pin = 1'b1;
	logic waiting_for_clock = 1'b0;
	wire [1:0] swing_code;
	wire [2:0] startup_trim_code;
	wire [9:0] swing_mv;
	wire [10:0] startup_trim_ps, fine_delay_ps;
	wire [5:0] delay_setpoint;
	wire input_bias_dc, fine_delay_enable, regulator_bypass, divider_run, startup_request;
	wire startup_delayed, cycle_drop_request, cycle_drop_pulse, launch_late;
	wire general_output_pin_o, general_output_pin_oe, serial_clk, serial_data_in, load_strobe;
	cdcfg_note_t q[$];
	cdcfg_note_t w;
	event shot;
	int seed = 91290;
	int num_errors = 0;
	int cmp_count = 0;
	int drops = 0;
	int ed = 0;
	logic [8:0] d, p;
	logic [5:0] v, e;
	logic b;
	logic [5:0] sp [3] = '{6'h00, 6'h3C, 6'h3F};
	logic [8:0] tg [5] = '{9'h003, 9'h003, 9'h000, 9'h007, 9'h1F9};
	logic [2:0] gs [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
	always #20 clk = ~clk;
	cdcfg_regs #(.CHIP_ADDR(3'h0)) u_dut (.*);
	cdcfg_host u_host (.*);
	always @(posedge clk)
		if (cycle_drop_pulse === 1'b1)
			drops <= drops + 1;
	// ----
	// checking
	// ----
	task automatic chk(input string n, input logic [10:0] s, input logic [10:0] x);
		cmp_count++;
		if (s !== x)
		begin
			num_errors++;
			$display("CHECK FAILED %s exp %0h got %0h", n, x, s);
		end
	endtask
	function automatic logic [10:0] obs(input int k);
		case (k)
			0: obs = 11'(swing_code);
			1: obs = 11'(swing_mv);
			2: obs = 11'(startup_trim_code);
			3: obs = startup_trim_ps;
			4: obs = 11'(delay_setpoint);
			5: obs = fine_delay_ps;
			6: obs = 11'({input_bias_dc, fine_delay_enable, regulator_bypass});
			7: obs = 11'(general_output_pin_o);
			8: obs = 11'(general_output_pin_oe);
			9: obs = 11'(divider_run);
			10: obs = 11'(launch_late);
			default: obs = 11'(drops);
		endcase
	endfunction
	task automatic note(input string n, input int k, input logic [10:0] x);
		q.push_back('{n, k, x});
		-> shot;
	endtask
	initial
		forever
		begin
			@(shot);
			while (q.size() > 0)
			begin
				w = q.pop_front();
				chk(w.n, obs(w.k), w.e);
			end
		end
	task automatic wr(input logic [2:0] c, input logic [3:0] a, input logic [8:0] x);
		u_host.send({x, a, c});
		@(negedge clk);
	endtask
	task automatic end_of_test;
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ----
	// watchdog and main sequence
	// ----
	initial
	begin
		repeat (90000) @(posedge clk);
		num_errors++;
		end_of_test;
	end
	initial
	begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (12) @(negedge clk);
		note("swing", 0, 11'h002);
		note("trim_ps", 3, 11'h4D8);
		note("fdly_ps", 5, 11'h17C);
		note("flags", 6, 11'h000);
		note("run", 9, 11'h001);
		for (int i = 0; i < 4; i++)
		begin
			d = 9'($random(seed));
			wr(3'h0, 4'h3, d);
			note("swing_mv", 1, 11'h258 + 11'h064 * d[5:4]);
			note("trim_ps", 3, 11'h3E8 + 11'h050 * d[8:6]);
			note("trim_code", 2, 11'(d[8:6]));
		end
		for (int i = 0; i < 4; i++)
		begin
			v = (i < 3) ? sp[i] : 6'($random(seed));
			e = (v > 6'h3C) ? 6'h3C : v;
			wr(3'h0, 4'h7, {3'h7, v});
			note("setpoint", 4, 11'(e));
			note("fdly_ps", 5, 11'h12C + 11'h014 * e);
		end
		wr(3'h0, 4'h4, 9'h02A);
		note("flags", 6, 11'h005);
		wr(3'h7, 4'h7, 9'h00A);
		wr(3'h0, 4'hF, 9'h011);
		wr(3'h0, 4'h4, 9'h03B);
		wr(3'h5, 4'h7, 9'h011);
		note("setpoint", 4, 11'(e));
		note("flags", 6, 11'h007);
		wr(3'h7, 4'h7, 9'h00A);
		note("setpoint", 4, 11'h00A);
		@(posedge clk);
		external_startup_pin <= 1'b0;
		repeat (10) @(negedge clk);
		note("run", 9, 11'h000);
		@(posedge clk);
		external_startup_pin <= 1'b1;
		p = 9'h001;
		foreach (tg[i])
		begin
			// each write that sets the drop bit keeps it up far longer than four cycles
			wr(3'h0, 4'h6, tg[i]);
			if (tg[i][1] && !p[1])
				ed++;
			p = tg[i];
			note("drops", 11, 11'(ed));
			note("late", 10, 11'(tg[i][2]));
			note("run", 9, 11'(tg[i][0]));
		end
		foreach (gs[i])
		begin
			b = 1'($random(seed));
			@(posedge clk);
			waiting_for_clock <= b;
			wr(3'h0, 4'h5, {6'h01, gs[i]});
			note("pin_o", 7, (gs[i] == 3'h1 || gs[i] == 3'h4 || gs[i] == 3'h5 ||
				(gs[i] == 3'h6 && b)) ? 11'h001 : 11'h000);
			note("pin_oe", 8, 11'h001);
		end
		wr(3'h0, 4'h5, 9'h019);
		note("pin_o", 7, 11'h000);
		@(posedge clk);
		serial_data_out <= 1'b1;
		repeat (10) @(negedge clk);
		note("pin_o", 7, 11'h001);
		wr(3'h0, 4'h5, 9'h031);
		note("pin_oe", 8, 11'h000);
		repeat (5) @(posedge clk);
		end_of_test;
	end
endmodule
bind cdcfg_regs cdcfg_chk u_chk (.*);
`default_nettype wire
